// [psbac_pkg.sv]
package psbac_pkg;

    // Register addresses on the serial register port
    localparam logic [7:0] ADDR_STATUS      = 8'h83;
    localparam logic [7:0] ADDR_BAL_CTRL    = 8'h84;
    localparam logic [7:0] ADDR_CONV_CTRL   = 8'h85;
    localparam logic [7:0] ADDR_OVERRIDE    = 8'h87;
    localparam logic [7:0] ADDR_RESULT_LO   = 8'hAA;
    localparam logic [7:0] ADDR_RESULT_HI   = 8'hAB;

    // Reset values
    localparam logic [7:0] RST_STATUS       = 8'h00;
    localparam logic [7:0] RST_BAL_CTRL     = 8'h00;
    localparam logic [7:0] RST_CONV_CTRL    = 8'h00;
    localparam logic [7:0] RST_OVERRIDE     = 8'h00;

    // Status field positions
    localparam int STS_SLEEP     = 6;
    localparam int STS_DOZE      = 5;
    localparam int STS_IDLE      = 4;
    localparam int STS_LOW_VOLT  = 3;
    localparam int STS_HIGH_VOLT = 2;
    localparam int STS_COLD      = 1;
    localparam int STS_HOT       = 0;

    // Conversion control field positions
    localparam int CONV_START    = 6;
    localparam int CONV_GAIN_HI  = 5;
    localparam int CONV_GAIN_LO  = 4;
    localparam int CONV_MUX_HI   = 3;
    localparam int CONV_MUX_LO   = 0;

    // Override register field positions
    localparam int OVR_FET       = 6;
    localparam int OVR_BAL       = 5;
    localparam int OVR_LOAD_MON  = 4;
    localparam int OVR_CHG_MON   = 3;
    localparam int OVR_SCAN      = 2;
    localparam int OVR_OPEN_WIRE = 1;
    localparam int OVR_BAL_ON    = 0;

    // Reserved top bit mask: RO reads zero, writes dropped
    localparam logic [7:0] WR_MASK_CONV     = 8'h7F;
    localparam logic [7:0] WR_MASK_OVR      = 8'h7F;

    // Sense amplifier gain codes
    typedef enum logic [1:0] {
        PSBAC_GAIN_X50,
        PSBAC_GAIN_X5,
        PSBAC_GAIN_X500
    } psbac_gain_t;

    // Analog multiplexer sources
    typedef enum logic [3:0] {
        PSBAC_SRC_OFF,
        PSBAC_SRC_CELL,
        PSBAC_SRC_PACK_CURRENT,
        PSBAC_SRC_BATTERY_DIV16,
        PSBAC_SRC_REGULATOR_DIV2,
        PSBAC_SRC_EXT_TEMP_ONE,
        PSBAC_SRC_EXT_TEMP_TWO,
        PSBAC_SRC_INT_TEMP
    } psbac_src_t;

    localparam logic [3:0] MUX_CELL_FIRST  = 4'h1;
    localparam logic [3:0] MUX_CELL_LAST   = 4'h8;
    localparam logic [3:0] MUX_PACK_CUR    = 4'h9;
    localparam logic [3:0] MUX_BAT_DIV     = 4'hA;
    localparam logic [3:0] MUX_REG_DIV     = 4'hB;
    localparam logic [3:0] MUX_EXT_ONE     = 4'hC;
    localparam logic [3:0] MUX_EXT_TWO     = 4'hD;
    localparam logic [3:0] MUX_INT_TEMP    = 4'hE;

    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;

endpackage

// [psbac_sync.sv]
`timescale 1ns/10ps
// Three-stage synchroniser; output changes once stages two and three agree
module psbac_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] stage_two;
    logic [WIDTH-1:0] stage_three;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_one   <= '0;
            stage_two   <= '0;
            stage_three <= '0;
        end else begin
            stage_one   <= async_in;
            stage_two   <= stage_one;
            stage_three <= stage_two;
        end
    end

    // Per bit: accept only when the two settled stages agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage_two[i] == stage_three[i]) begin
                    sync_out[i] <= stage_three[i];
                end
            end
        end
    end

endmodule // psbac_sync

// [psbac_regs.sv]
`timescale 1ns/10ps
// Functional notes
// - Status flags follow their conditions by hardware; host writes ignored.
// - Sleep flag set on sleep entry; cleared at power-up, charger rise, load fall, sleep exit.
// - Doze flag reads one while device is doze_mode_flag mode.
// - Idle flag reads one while device is in idle mode.
// - All mode flags zero: normal or powered down; powered down is silent.
// - Low-voltage flag set when all cells below minimum; clears otherwise.
// - High-voltage flag set when all cells above maximum; clears otherwise.
// - Cold flag set while pack below low-temperature limit.
// - Hot flag set while pack above high-temperature limit.
// - Balance control bits drive balance outputs only under balance override.
// - Balance bit zero requests off, one requests on; all reset zero.
// - Under override without fault, output on only if global balance-on and cell bit.
// - Without override, automatic balancing owns outputs and may use bits.
// - Start, gain and mux fields act only under scan override.
// - Start bit launches one conversion and self-clears.
// - Gain field: 00 x50, 01 x5, 10 and 11 x500.
// - Mux field selects off, cells, current, battery, regulator, temps.
// - Manual conversion results under scan override land in result pair.
// - Override register holds override bits, open-wire start, balance-on.
module psbac_regs #(
    parameter int CELLS       = 8,
    parameter int RESULT_BITS = 16
) (
    // Clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // Register port
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [7:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    output logic                        reg_ack,
    // Power state from the mode controller
    input  wire logic                   powered_down,
    input  wire logic                   sleep_mode,
    input  wire logic                   doze_mode,
    input  wire logic                   idle_mode,
    // Monitor pins
    input  wire logic                   charger_monitor_input,
    input  wire logic                   load_monitor_input,
    // Balance conditions from the measurement comparators
    input  wire logic                   cells_below_min,
    input  wire logic                   cells_above_max,
    input  wire logic                   pack_below_cold,
    input  wire logic                   pack_above_hot,
    input  wire logic                   balance_fault,
    // Automatic engine
    input  wire logic [CELLS-1:0]       auto_balance_out,
    input  wire logic                   auto_conv_start,
    input  wire logic [1:0]             auto_gain,
    input  wire logic [3:0]             auto_mux,
    // Converter
    input  wire logic                   conv_done,
    input  wire logic [RESULT_BITS-1:0] conv_result,
    output logic                        conv_start,
    output logic [1:0]                  amp_gain,
    output psbac_pkg::psbac_src_t       mux_source,
    output logic [3:0]                  mux_cell,
    // Balance FET drives
    output logic [CELLS-1:0]            balance_out,
    // Override outputs toward neighbouring logic
    output logic                        host_fet_override,
    output logic                        host_load_mon_override,
    output logic                        host_charger_mon_override,
    output logic                        open_wire_start,
    output logic                        host_balance_override,
    output logic                        host_scan_override,
    output logic                        global_balance_on
);

    logic [1:0]             mon_sync;
    logic                   chg_prev;
    logic                   load_prev;
    logic                   sleep_flag;
    logic                   sleep_prev;
    logic [3:0]             bal_flags;
    logic [7:0]             cell_balance_output_control;
    logic                   conversion_start_bit;
    logic [1:0]             current_gain_field;
    logic [3:0]             mux_select_field;
    logic [7:0]             override_ctrl;
    logic [RESULT_BITS-1:0] manual_conversion_result;
    logic [7:0]             status_word;
    logic                   wr_ok;
    logic [1:0]             sel_gain;
    logic [3:0]             sel_mux;

    // Gain code to amplifier setting
    function automatic logic [1:0] gain_decode(input logic [1:0] code);
        case (code)
            2'h0:    gain_decode = psbac_pkg::PSBAC_GAIN_X50;
            2'h1:    gain_decode = psbac_pkg::PSBAC_GAIN_X5;
            default: gain_decode = psbac_pkg::PSBAC_GAIN_X500;
        endcase
    endfunction

    // Mux code to source class
    function automatic psbac_pkg::psbac_src_t mux_decode(
        input logic [3:0] code);
        if (code >= psbac_pkg::MUX_CELL_FIRST &&
            code <= psbac_pkg::MUX_CELL_LAST) begin
            mux_decode = psbac_pkg::PSBAC_SRC_CELL;
        end else begin
            case (code)
                psbac_pkg::MUX_PACK_CUR:
                    mux_decode = psbac_pkg::PSBAC_SRC_PACK_CURRENT;
                psbac_pkg::MUX_BAT_DIV:
                    mux_decode = psbac_pkg::PSBAC_SRC_BATTERY_DIV16;
                psbac_pkg::MUX_REG_DIV:
                    mux_decode = psbac_pkg::PSBAC_SRC_REGULATOR_DIV2;
                psbac_pkg::MUX_EXT_ONE:
                    mux_decode = psbac_pkg::PSBAC_SRC_EXT_TEMP_ONE;
                psbac_pkg::MUX_EXT_TWO:
                    mux_decode = psbac_pkg::PSBAC_SRC_EXT_TEMP_TWO;
                psbac_pkg::MUX_INT_TEMP:
                    mux_decode = psbac_pkg::PSBAC_SRC_INT_TEMP;
                default:
                    mux_decode = psbac_pkg::PSBAC_SRC_OFF;
            endcase
        end
    endfunction

    psbac_sync #(
        .WIDTH(2)
    ) u_mon_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in ({charger_monitor_input, load_monitor_input}),
        .sync_out (mon_sync)
    );

    // Powered down: no register access is answered
    assign wr_ok = reg_wr && !powered_down;

    // Sleep flag: set on sleep entry, cleared by charger rise or load fall
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            chg_prev   <= 1'b0;
            load_prev  <= 1'b0;
            sleep_prev <= 1'b0;
            sleep_flag <= 1'b0;
        end else begin
            chg_prev   <= mon_sync[1];
            load_prev  <= mon_sync[0];
            sleep_prev <= sleep_mode;
            if ((mon_sync[1] && !chg_prev) ||
                (!mon_sync[0] && load_prev) || !sleep_mode) begin
                sleep_flag <= 1'b0;
            end else if (sleep_mode && !sleep_prev) begin
                sleep_flag <= 1'b1;
            end
        end
    end

    // Condition flags track their causes; no write path exists
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bal_flags <= 4'h0;
        end else begin
            bal_flags <= {cells_below_min,
                          cells_above_max,
                          pack_below_cold,
                          pack_above_hot};
        end
    end

    // Status word; top bit reads zero
    always_comb begin
        status_word = psbac_pkg::RST_STATUS;
        status_word[psbac_pkg::STS_SLEEP] = sleep_flag;
        status_word[psbac_pkg::STS_DOZE]  = doze_mode;
        status_word[psbac_pkg::STS_IDLE]  = idle_mode;
        status_word[psbac_pkg::STS_LOW_VOLT:psbac_pkg::STS_HOT] = bal_flags;
    end

    // Per-cell balance request bits
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cell_balance_output_control <= psbac_pkg::RST_BAL_CTRL;
        end else if (wr_ok && reg_addr == psbac_pkg::ADDR_BAL_CTRL) begin
            cell_balance_output_control <= reg_wdata;
        end
    end

    // Override control register; reserved bit kept zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            override_ctrl <= psbac_pkg::RST_OVERRIDE;
        end else if (wr_ok && reg_addr == psbac_pkg::ADDR_OVERRIDE) begin
            override_ctrl <= reg_wdata & psbac_pkg::WR_MASK_OVR;
        end else begin
            // Open-wire start is a one-shot request
            override_ctrl[psbac_pkg::OVR_OPEN_WIRE] <= 1'b0;
        end
    end

    assign host_fet_override         = override_ctrl[psbac_pkg::OVR_FET];
    assign host_balance_override     = override_ctrl[psbac_pkg::OVR_BAL];
    assign host_load_mon_override    = override_ctrl[psbac_pkg::OVR_LOAD_MON];
    assign host_charger_mon_override = override_ctrl[psbac_pkg::OVR_CHG_MON];
    assign host_scan_override        = override_ctrl[psbac_pkg::OVR_SCAN];
    assign open_wire_start           = override_ctrl[psbac_pkg::OVR_OPEN_WIRE];
    assign global_balance_on         = override_ctrl[psbac_pkg::OVR_BAL_ON];

    // Conversion control fields; start bit clears after one cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conversion_start_bit <= 1'b0;
            current_gain_field   <= 2'h0;
            mux_select_field     <= 4'h0;
        end else if (wr_ok && reg_addr == psbac_pkg::ADDR_CONV_CTRL) begin
            conversion_start_bit <= reg_wdata[psbac_pkg::CONV_START];
            current_gain_field   <=
                reg_wdata[psbac_pkg::CONV_GAIN_HI:psbac_pkg::CONV_GAIN_LO];
            mux_select_field     <=
                reg_wdata[psbac_pkg::CONV_MUX_HI:psbac_pkg::CONV_MUX_LO];
        end else begin
            conversion_start_bit <= 1'b0;
        end
    end

    // Manual fields only steer the converter under scan override
    assign sel_gain = host_scan_override ? current_gain_field
                                         : auto_gain;
    assign sel_mux  = host_scan_override ? mux_select_field
                                         : auto_mux;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start <= 1'b0;
            amp_gain   <= psbac_pkg::PSBAC_GAIN_X50;
            mux_source <= psbac_pkg::PSBAC_SRC_OFF;
            mux_cell   <= 4'h0;
        end else begin
            conv_start <= host_scan_override ? conversion_start_bit
                                             : auto_conv_start;
            amp_gain   <= gain_decode(sel_gain);
            mux_source <= mux_decode(sel_mux);
            mux_cell   <= (mux_decode(sel_mux) == psbac_pkg::PSBAC_SRC_CELL)
                          ? sel_mux : 4'h0;
        end
    end

    // Result pair captures manual conversions only
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            manual_conversion_result <= '0;
        end else if (conv_done && host_scan_override) begin
            manual_conversion_result <= conv_result;
        end
    end

    // Balance outputs: host bits under override, else automatic engine
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            balance_out <= '0;
        end else if (balance_fault) begin
            balance_out <= '0;
        end else if (host_balance_override) begin
            balance_out <= global_balance_on
                ? cell_balance_output_control[CELLS-1:0]
                : '0;
        end else begin
            balance_out <= auto_balance_out;
        end
    end

    // Read path; unmapped addresses read zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            reg_ack   <= 1'b0;
        end else begin
            reg_ack <= (reg_rd || reg_wr) && !powered_down;
            if (reg_rd && !powered_down) begin
                case (reg_addr)
                    psbac_pkg::ADDR_STATUS:    reg_rdata <= status_word;
                    psbac_pkg::ADDR_BAL_CTRL:
                        reg_rdata <= cell_balance_output_control;
                    psbac_pkg::ADDR_CONV_CTRL:
                        reg_rdata <= {1'b0, conversion_start_bit,
                                      current_gain_field, mux_select_field};
                    psbac_pkg::ADDR_OVERRIDE:  reg_rdata <= override_ctrl;
                    psbac_pkg::ADDR_RESULT_LO:
                        reg_rdata <= manual_conversion_result[7:0];
                    psbac_pkg::ADDR_RESULT_HI:
                        reg_rdata <= manual_conversion_result[15:8];
                    default:                   reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule // psbac_regs

// [psbac_regs_assertions.sv]
`timescale 1ns/10ps
module psbac_regs_assertions #(
    parameter int CELLS = 8
) (
    // Clock and reset
    input wire logic                  sys_clk,
    input wire logic                  rst_n,
    // Register port
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic                  reg_ack,
    input wire logic                  powered_down,
    // Balance
    input wire logic                  balance_fault,
    input wire logic [CELLS-1:0]      auto_balance_out,
    input wire logic [CELLS-1:0]      balance_out,
    input wire logic                  host_balance_override,
    input wire logic                  global_balance_on,
    input wire logic                  open_wire_start,
    // Converter
    input wire logic                  auto_conv_start,
    input wire logic                  conv_start,
    input wire logic                  host_scan_override,
    input wire logic [1:0]            amp_gain,
    input wire psbac_pkg::psbac_src_t mux_source,
    input wire logic [3:0]            mux_cell
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_ack_cause: assert property (
        reg_ack |-> !$past(powered_down) && ($past(reg_wr) || $past(reg_rd)))
        else $error("ack without accepted access");
    a_start_pulse: assert property (
        host_scan_override && conv_start |=> !conv_start)
        else $error("manual start longer than one cycle");
    a_scan_auto: assert property (
        !host_scan_override |=> conv_start == $past(auto_conv_start))
        else $error("start not from automatic engine");
    a_gain_legal: assert property (
        amp_gain != 2'h3)
        else $error("illegal gain code");
    a_cell_range: assert property (
        mux_source == psbac_pkg::PSBAC_SRC_CELL |-> mux_cell inside {[1:8]})
        else $error("cell number out of range");
    a_cell_zero: assert property (
        mux_source != psbac_pkg::PSBAC_SRC_CELL |-> mux_cell == 4'h0)
        else $error("cell number without cell source");
    a_fault_off: assert property (
        balance_fault |=> balance_out == '0)
        else $error("balance output on during fault");
    a_bal_gate: assert property (
        host_balance_override && !global_balance_on |=> balance_out == '0)
        else $error("balance output on without balance on");
    a_auto_balance: assert property (
        !host_balance_override && global_balance_on && !balance_fault
        |=> balance_out == $past(auto_balance_out))
        else $error("automatic balance not passed through");
    a_open_wire: assert property (
        open_wire_start |=> !open_wire_start)
        else $error("open wire start not a pulse");
endmodule // psbac_regs_assertions

bind psbac_regs psbac_regs_assertions #(.CELLS(CELLS)) u_chk (
    .sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_ack, .powered_down,
    .balance_fault, .auto_balance_out, .balance_out,
    .host_balance_override, .global_balance_on, .open_wire_start,
    .auto_conv_start, .conv_start, .host_scan_override, .amp_gain,
    .mux_source, .mux_cell);

// [psbac_host_model.sv]
`timescale 1ns/10ps
module psbac_host_model (
    // Clock
    input  wire logic       sys_clk,
    // Register port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_ack
);
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    end

    // One-cycle strobe; answer taken one edge after it is seen
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q,
                          output logic ok);
        @(posedge sys_clk);
        reg_wr <= wr;
        reg_rd <= !wr;
        reg_addr <= a;
        reg_wdata <= (a == 8'h85 || a == 8'h87) ? (d & 8'h7F) : d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        ok = reg_ack;
        q = (a == 8'h83 || a == 8'h85 || a == 8'h87)
            ? {1'b0, reg_rdata[6:0]} : reg_rdata;
        // Released lines show garbage, not the last value
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
endmodule // psbac_host_model

// [pack_status_balance_adc_ctrl_test.sv]
`timescale 1ns/10ps
module pack_status_balance_adc_ctrl_test;
    logic                  sys_clk, rst_n, reg_wr, reg_rd, reg_ack;
    logic                  powered_down, sleep_mode, doze_mode, idle_mode;
    logic                  charger_monitor_input, load_monitor_input;
    logic                  cells_below_min, cells_above_max, balance_fault;
    logic                  pack_below_cold, pack_above_hot, ok;
    logic                  auto_conv_start, conv_done, conv_start;
    logic [7:0]            reg_addr, reg_wdata, reg_rdata, q, v;
    logic [7:0]            auto_balance_out, balance_out;
    logic [1:0]            auto_gain, amp_gain;
    logic [3:0]            auto_mux, mux_cell;
    logic [15:0]           conv_result, cres;
    wire  [6:0]            ovr_pins;
    psbac_pkg::psbac_src_t mux_source;
    int                    err_count, n_checks, i;
    logic [7:0]            rst_addr [4] = '{8'h83, 8'h84, 8'h85, 8'h87};

    psbac_host_model host (.sys_clk, .reg_wr, .reg_rd, .reg_addr,
                           .reg_wdata, .reg_rdata, .reg_ack);

    psbac_regs uut (.sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_ack, .powered_down, .sleep_mode,
        .doze_mode, .idle_mode, .charger_monitor_input, .load_monitor_input,
        .cells_below_min, .cells_above_max, .pack_below_cold,
        .pack_above_hot, .balance_fault, .auto_balance_out,
        .auto_conv_start, .auto_gain, .auto_mux, .conv_done, .conv_result,
        .conv_start, .amp_gain, .mux_source, .mux_cell, .balance_out,
        .host_fet_override(ovr_pins[6]),
        .host_balance_override(ovr_pins[5]),
        .host_load_mon_override(ovr_pins[4]),
        .host_charger_mon_override(ovr_pins[3]),
        .host_scan_override(ovr_pins[2]), .open_wire_start(ovr_pins[1]),
        .global_balance_on(ovr_pins[0]));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        host.access(1'b1, a, d, q, ok);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.access(1'b0, a, 8'h00, q, ok);
        chk(q, e);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [7:0] exp_sts(input logic s);
        return {1'b0, s, doze_mode, idle_mode, cells_below_min,
                cells_above_max, pack_below_cold, pack_above_hot};
    endfunction

    function automatic logic [7:0] exp_src(input logic [3:0] m);
        if (m == 4'h0 || m == 4'hF) return 8'h00;
        if (m <= 4'h8) return 8'h01;
        return {4'h0, 4'(m - 4'h7)};
    endfunction

    task automatic give_verdict;
        if (err_count == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        err_count++;
        give_verdict;
    end

    initial begin
        rst_n = 1'b0;
        {powered_down, sleep_mode, doze_mode, idle_mode} = '0;
        {charger_monitor_input, balance_fault, conv_done} = '0;
        {cells_below_min, cells_above_max} = '0;
        {pack_below_cold, pack_above_hot, auto_conv_start} = '0;
        load_monitor_input = 1'b1;
        {auto_balance_out, auto_gain, auto_mux, conv_result} = '0;
        err_count = 0;
        n_checks = 0;
        void'($urandom(85));
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (rst_addr[k]) rd_chk(rst_addr[k], 8'h00);
        rd_chk(8'h90, 8'h00);
        for (i = 0; i < 24; i++) begin
            @(posedge sys_clk);
            {doze_mode, idle_mode, cells_below_min, cells_above_max,
             pack_below_cold, pack_above_hot} <= 6'($urandom);
            auto_conv_start <= 1'($urandom);
            auto_balance_out <= 8'($urandom);
            wr8(8'h83, 8'hFF);
            rd_chk(8'h83, exp_sts(1'b0));
        end
        sleep_mode <= 1'b1;
        settle(2);
        rd_chk(8'h83, exp_sts(1'b1));
        charger_monitor_input <= 1'b1;
        settle(6);
        rd_chk(8'h83, exp_sts(1'b0));
        {charger_monitor_input, sleep_mode} <= 2'b00;
        settle(6);
        sleep_mode <= 1'b1;
        settle(2);
        rd_chk(8'h83, exp_sts(1'b1));
        load_monitor_input <= 1'b0;
        settle(6);
        rd_chk(8'h83, exp_sts(1'b0));
        powered_down <= 1'b1;
        wr8(8'h84, 8'hFF);
        chk({7'h00, ok}, 8'h00);
        powered_down <= 1'b0;
        rd_chk(8'h84, 8'h00);
        // Override, open-wire start and balance on together
        wr8(8'h87, 8'h23);
        rd_chk(8'h87, 8'h21);
        chk({1'b0, ovr_pins}, 8'h21);
        for (i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            wr8(8'h84, v);
            settle(1);
            chk(balance_out, v);
            rd_chk(8'h84, v);
        end
        wr8(8'h84, 8'hFF);
        wr8(8'h87, 8'h20);
        settle(1);
        chk(balance_out, 8'h00);
        wr8(8'h87, 8'h21);
        balance_fault <= 1'b1;
        settle(2);
        chk(balance_out, 8'h00);
        balance_fault <= 1'b0;
        wr8(8'h87, 8'h01);
        auto_balance_out <= 8'hA5;
        settle(2);
        chk(balance_out, 8'hA5);
        wr8(8'h87, 8'h05);
        for (i = 0; i < 20; i++) begin
            v = (i < 16) ? {2'b01, 2'(i >> 2), 4'(i)}
                         : {2'b01, 6'($urandom)};
            wr8(8'h85, v);
            // Start pulse stands only in the second cycle after the write lands, one cycle behind the start bit
            settle(0);
            chk({7'h00, conv_start}, 8'h01);
            chk({6'h00, amp_gain}, v[5] ? 8'h02 : {7'h00, v[4]});
            chk(8'(mux_source), exp_src(v[3:0]));
            chk({4'h0, mux_cell}, (v[3:0] inside {[4'h1:4'h8]})
                ? {4'h0, v[3:0]} : 8'h00);
            settle(1);
            chk({7'h00, conv_start}, 8'h00);
            rd_chk(8'h85, v & 8'h3F);
        end
        cres = 16'($urandom);
        @(posedge sys_clk);
        conv_result <= cres;
        conv_done <= 1'b1;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        rd_chk(8'hAA, cres[7:0]);
        rd_chk(8'hAB, cres[15:8]);
        wr8(8'h87, 8'h00);
        {auto_conv_start, auto_gain, auto_mux} <= {1'b0, 2'h3, 4'hC};
        wr8(8'h85, 8'h45);
        settle(1);
        chk({7'h00, conv_start}, 8'h00);
        chk({6'h00, amp_gain}, 8'h02);
        chk(8'(mux_source), 8'h05);
        conv_result <= ~cres;
        conv_done <= 1'b1;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        rd_chk(8'hAA, cres[7:0]);
        give_verdict;
    end
endmodule // pack_status_balance_adc_ctrl_test
